// ### rtl/ssd_pkg.sv
// Constants shared by the two-wire select-byte decoder.
// Assumes one clock domain; link pins are synchronised in the top module.
package ssd_pkg;
    // Type identifiers in bits 7..4 of the select byte
    localparam logic [3:0] TYPE_MEM = 4'hA;
    localparam logic [3:0] TYPE_PROT = 4'h6;
    localparam logic [3:0] TYPE_TEMP = 4'h3;
    // Bits 3..0 of protection-group select bytes (b3 b2 b1 rw)
    localparam logic [3:0] CODE_SWP0 = 4'h2;
    localparam logic [3:0] CODE_SWP1 = 4'h8;
    localparam logic [3:0] CODE_SWP2 = 4'hA;
    localparam logic [3:0] CODE_SWP3 = 4'h0;
    localparam logic [3:0] CODE_CWP = 4'h6;
    localparam logic [3:0] CODE_RPS0 = 4'h3;
    localparam logic [3:0] CODE_RPS1 = 4'h9;
    localparam logic [3:0] CODE_RPS2 = 4'hB;
    localparam logic [3:0] CODE_RPS3 = 4'h1;
    localparam logic [3:0] CODE_SELECT_LOWER_PAGE = 4'hC;
    localparam logic [3:0] CODE_SELECT_UPPER_PAGE = 4'hE;
    localparam logic [3:0] CODE_RPA = 4'hD;
    // Bit counter marks: eighth bit taken, acknowledge clock taken
    localparam logic [3:0] CNT_BYTE = 4'h8;
    localparam logic [3:0] CNT_ACK = 4'h9;
    // Byte index of the first data byte (select=0, address=1)
    localparam logic [1:0] IDX_DATA = 2'h2;
    // Reset values
    localparam logic PAGE_RST = 1'b0;
    // Link states, one-hot
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_SEL = 3'b010,
        ST_DATA = 3'b100
    } ssd_state_e;
endpackage

// ### rtl/ssd_top.sv
// Two-wire slave front end: start/stop detect, select byte decode, acknowledge.
// Assumes scl/sda and strap pins are asynchronous; write_busy and
// prot_status come from logic on ref_clk. The sda pin is open drain.
// Behaviour
// - Start is sda falling while scl high
// - Watch for start always; ignore until seen
// - Stop is sda rising while scl high
// - Read ended by nack+stop: memory standby
// - Stop after write ack starts programming
// - Receiver pulls sda low in 9th clock
// - Sda high in 9th clock means nack
// - Data bits captured on scl rising edge
// - Select byte: type, address, direction, msb first
// - Type code routes memory, protection or temperature
// - Protect set/clear needs high voltage strap
// - Memory/temperature answer only on address match
// - Protection/page commands ignore strap address
// - Eighth bit one reads, zero writes
// - Matching select byte is acknowledged (code nacks a memory select while write_busy)
// - Non-memory select puts memory in standby
// - Protection codes need high voltage, write
// - Block bits mapped explicitly, legacy order
// - Status reads accepted at any strap level
// - Page commands select lower or upper half
// - Page read acks page 0, nacks 1
// - Device never holds the clock low
// - Strap address: pin2 msb, pin0 lsb
// - Status data byte acked only if unprotected
// - Page is 0 after power-on reset
`timescale 1ns/1ps
module ssd_top
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic strap_addr_bit0_hv_detect,
    input wire logic strap_addr_bit1,
    input wire logic strap_addr_bit2,
    input wire logic high_voltage_qualifier,
    input wire logic write_busy,
    input wire logic [3:0] prot_status,
    output logic memory_page,
    output logic set_block_protect,
    output logic [1:0] protect_block,
    output logic clear_all_protect,
    output logic write_cycle_start,
    output logic memory_standby,
    output logic memory_selected,
    output logic thermal_selected,
    output logic read_dir
);
    import ssd_pkg::*;

    // Legacy block order of protection codes
    function automatic logic [1:0] prot_block_of(input logic [3:0] code);
        unique case (code)
            CODE_SWP0, CODE_RPS0: prot_block_of = 2'h0;
            CODE_SWP1, CODE_RPS1: prot_block_of = 2'h1;
            CODE_SWP2, CODE_RPS2: prot_block_of = 2'h2;
            default: prot_block_of = 2'h3;
        endcase
    endfunction

    // Two-stage synchronisers; stage 0 feeds only stage 1
    logic [5:0] sy0_q; // First stage
    logic [5:0] sy1_q; // Second stage, safe to use
    logic scl_p_q; // Previous synced scl
    logic sda_p_q; // Previous synced sda
    ssd_state_e state_q; // Link state
    logic [3:0] bit_cnt_q; // Bits taken in this byte
    logic [1:0] byte_idx_q; // Byte index, saturating
    logic [7:0] shift_q; // Incoming bits
    logic ack_q; // Acknowledge planned for this byte
    logic mem_q; // Memory group selected
    logic temp_q; // Temperature group selected
    logic rw_q; // Direction bit
    logic [3:0] code_q; // Low nibble of select byte
    logic armed_q; // Ack of a memory data byte just ended
    logic mnack_q; // Master left 9th clock high
    logic oe_n_q; // Open-drain enable, low drives
    logic page_q; // Selected memory page
    logic swp_q;
    logic [1:0] blk_q;
    logic cwp_q;
    logic wcyc_q;
    logic stby_q;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            // Link lines start at their idle high level, so release shows no false edge
            sy0_q <= 6'h03;
            sy1_q <= 6'h03;
        end
        else
        begin
            sy0_q <= {high_voltage_qualifier, strap_addr_bit2, strap_addr_bit1,
                      strap_addr_bit0_hv_detect, sda_in, scl_in};
            sy1_q <= sy0_q;
        end
    end

    logic scl_s;
    logic sda_s;
    logic [2:0] strap_addr; // Logical strap address
    logic hv_s;
    assign scl_s = sy1_q[0];
    assign sda_s = sy1_q[1];
    assign strap_addr = sy1_q[4:2];
    assign hv_s = sy1_q[5];

    // Edge history of the synced link lines
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // Line events; scl stable high across both samples
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    assign scl_rise = scl_s & ~scl_p_q;
    assign scl_fall = ~scl_s & scl_p_q;
    assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // Select byte fields as they complete on the eighth rise
    logic [7:0] sel_byte;
    logic sel_rise;
    logic data_rise;
    logic addr_ok;
    logic is_spa;
    logic sel_ack;
    logic data_ack;
    assign sel_byte = {shift_q[6:0], sda_s};
    assign sel_rise = scl_rise & (state_q == ST_SEL) & (bit_cnt_q == CNT_BYTE - 4'h1);
    assign data_rise = scl_rise & (state_q == ST_DATA) & (bit_cnt_q == CNT_BYTE - 4'h1);
    assign addr_ok = sel_byte[3:1] == strap_addr;
    assign is_spa = (sel_byte[3:0] == CODE_SELECT_LOWER_PAGE) | (sel_byte[3:0] == CODE_SELECT_UPPER_PAGE);

    // Acknowledge choice for the select byte
    always_comb
    begin
        sel_ack = 1'b0;
        if (sel_byte[7:4] == TYPE_MEM)
            sel_ack = addr_ok & ~write_busy;
        else if (sel_byte[7:4] == TYPE_TEMP)
            sel_ack = addr_ok;
        else if (sel_byte[7:4] == TYPE_PROT)
        begin
            // Strap address not compared here
            unique case (sel_byte[3:0])
                CODE_SWP0, CODE_SWP1, CODE_SWP2, CODE_SWP3, CODE_CWP: sel_ack = hv_s;
                CODE_RPS0, CODE_RPS1, CODE_RPS2, CODE_RPS3: sel_ack = 1'b1;
                CODE_SELECT_LOWER_PAGE, CODE_SELECT_UPPER_PAGE: sel_ack = 1'b1;
                CODE_RPA: sel_ack = ~page_q;
                default: sel_ack = 1'b0;
            endcase
        end
    end

    // Acknowledge choice for later bytes
    always_comb
    begin
        data_ack = 1'b1;
        if (~mem_q & ~temp_q & code_q[0] & (code_q != CODE_RPA))
            data_ack = ~prot_status[prot_block_of(code_q)];
        else if (rw_q)
            data_ack = 1'b0; // Master acks read bytes
        else if (mem_q)
            data_ack = ~write_busy;
    end

    // Link state; start is honoured in every state
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            state_q <= ST_IDLE;
        else if (start_ev)
            state_q <= ST_SEL;
        else if (stop_ev)
            state_q <= ST_IDLE;
        else if (scl_fall & (bit_cnt_q == CNT_ACK) & (state_q == ST_SEL))
            state_q <= ack_q ? ST_DATA : ST_IDLE;
    end

    // Bit and byte counting, sampling on scl rise
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bit_cnt_q <= 4'h0;
            byte_idx_q <= 2'h0;
            shift_q <= 8'h00;
            mnack_q <= 1'b0;
        end
        else if (start_ev | stop_ev)
        begin
            bit_cnt_q <= 4'h0;
            byte_idx_q <= 2'h0;
            mnack_q <= 1'b0;
        end
        else if (state_q != ST_IDLE)
        begin
            if (scl_rise & (bit_cnt_q < CNT_BYTE))
            begin
                shift_q <= sel_byte;
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            else if (scl_rise & (bit_cnt_q == CNT_BYTE))
            begin
                bit_cnt_q <= CNT_ACK;
                mnack_q <= sda_s;
            end
            else if (scl_fall & (bit_cnt_q == CNT_ACK))
            begin
                bit_cnt_q <= 4'h0;
                if (byte_idx_q != 2'h3)
                    byte_idx_q <= byte_idx_q + 2'h1;
            end
        end
    end

    // Transaction routing latched from the select byte
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ack_q <= 1'b0;
            mem_q <= 1'b0;
            temp_q <= 1'b0;
            rw_q <= 1'b0;
            code_q <= 4'h0;
        end
        else if (stop_ev)
        begin
            mem_q <= 1'b0;
            temp_q <= 1'b0;
        end
        else if (sel_rise)
        begin
            ack_q <= sel_ack;
            mem_q <= (sel_byte[7:4] == TYPE_MEM) & sel_ack;
            temp_q <= (sel_byte[7:4] == TYPE_TEMP) & sel_ack;
            rw_q <= sel_byte[0];
            code_q <= sel_byte[3:0];
        end
        else if (data_rise)
            ack_q <= data_ack;
    end

    // Open-drain drive: low from the fall after bit 8 to the fall after bit 9
    // Only sda is ever driven; scl has no output at all
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            oe_n_q <= 1'b1;
            sda_out <= 1'b1;
        end
        else if (start_ev | stop_ev | (state_q == ST_IDLE))
        begin
            oe_n_q <= 1'b1;
            sda_out <= 1'b1;
        end
        else if (scl_fall & (bit_cnt_q == CNT_BYTE) & ack_q)
        begin
            oe_n_q <= 1'b0;
            sda_out <= 1'b0;
        end
        else if (scl_fall & (bit_cnt_q == CNT_ACK))
        begin
            oe_n_q <= 1'b1;
            sda_out <= 1'b1;
        end
    end
    assign sda_oe_n = oe_n_q;

    // Page register and protection command pulses
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            page_q <= PAGE_RST;
            swp_q <= 1'b0;
            blk_q <= 2'h0;
            cwp_q <= 1'b0;
        end
        else
        begin
            swp_q <= 1'b0;
            cwp_q <= 1'b0;
            if (sel_rise & (sel_byte[7:4] == TYPE_PROT) & sel_ack)
            begin
                if (is_spa)
                    page_q <= sel_byte[1];
                swp_q <= ~sel_byte[0] & ~is_spa & (sel_byte[3:0] != CODE_CWP);
                cwp_q <= sel_byte[3:0] == CODE_CWP;
                blk_q <= prot_block_of(sel_byte[3:0]);
            end
        end
    end

    // Write-cycle trigger and memory standby
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            armed_q <= 1'b0;
            wcyc_q <= 1'b0;
            stby_q <= 1'b0;
        end
        else
        begin
            wcyc_q <= stop_ev & armed_q;
            stby_q <= (stop_ev & mem_q & rw_q & mnack_q)
                      | (sel_rise & (sel_byte[7:4] != TYPE_MEM));
            // A stop raises scl before sda, so only a fall outside the ack slot disarms
            if (start_ev | stop_ev | (scl_fall & (bit_cnt_q != CNT_ACK)))
                armed_q <= 1'b0;
            else if (scl_fall & (bit_cnt_q == CNT_ACK))
                armed_q <= mem_q & ~rw_q & ack_q & (byte_idx_q >= IDX_DATA);
        end
    end

    assign memory_page = page_q;
    assign set_block_protect = swp_q;
    assign protect_block = blk_q;
    assign clear_all_protect = cwp_q;
    assign write_cycle_start = wcyc_q;
    assign memory_standby = stby_q;
    assign memory_selected = mem_q;
    assign thermal_selected = temp_q;
    assign read_dir = rw_q;

    // Checks
    property p_ack_slot;
        @(posedge ref_clk) disable iff (!nrst)
        $fell(oe_n_q) |-> $past(bit_cnt_q) == CNT_BYTE && $past(ack_q);
    endproperty
    a_ack_slot: assert property (p_ack_slot) else $error("ack driven outside 9th slot");

    property p_idle_quiet;
        @(posedge ref_clk) disable iff (!nrst)
        state_q == ST_IDLE && $past(state_q) == ST_IDLE |-> oe_n_q;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("sda driven while idle");

    property p_start_sel;
        @(posedge ref_clk) disable iff (!nrst)
        start_ev |=> state_q == ST_SEL && bit_cnt_q == 4'h0 ##1 oe_n_q;
    endproperty
    a_start_sel: assert property (p_start_sel) else $error("start not honoured");

    property p_stop_idle;
        @(posedge ref_clk) disable iff (!nrst)
        stop_ev |=> state_q == ST_IDLE ##1 oe_n_q;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop did not end exchange");

    property p_capture;
        @(posedge ref_clk) disable iff (!nrst)
        scl_rise && state_q != ST_IDLE && bit_cnt_q < CNT_BYTE && !start_ev && !stop_ev
        |=> shift_q[0] == $past(sda_s);
    endproperty
    a_capture: assert property (p_capture) else $error("bit not captured on rise");

    property p_addr_match;
        @(posedge ref_clk) disable iff (!nrst)
        sel_rise && sel_byte[7:4] != TYPE_PROT && !addr_ok |=> !ack_q ##1 oe_n_q;
    endproperty
    a_addr_match: assert property (p_addr_match) else $error("acked foreign address");

    property p_hv_needed;
        @(posedge ref_clk) disable iff (!nrst)
        sel_rise && sel_byte[7:4] == TYPE_PROT && !sel_byte[0] && !is_spa && !hv_s |=> !swp_q && !cwp_q;
    endproperty
    a_hv_needed: assert property (p_hv_needed) else $error("protect change without hv");

    property p_rpa;
        @(posedge ref_clk) disable iff (!nrst)
        sel_rise && sel_byte == {TYPE_PROT, CODE_RPA} |=> ack_q == !page_q;
    endproperty
    a_rpa: assert property (p_rpa) else $error("page read answer wrong");

    property p_page_cause;
        @(posedge ref_clk) disable iff (!nrst)
        $changed(page_q) |-> $past(sel_rise && is_spa && sel_byte[7:4] == TYPE_PROT);
    endproperty
    a_page_cause: assert property (p_page_cause) else $error("page changed without command");

    property p_wcyc;
        @(posedge ref_clk) disable iff (!nrst)
        wcyc_q |-> $past(stop_ev) && $past(armed_q);
    endproperty
    a_wcyc: assert property (p_wcyc) else $error("write cycle without stop after ack");

    c_mem_write: cover property (@(posedge ref_clk) disable iff (!nrst) wcyc_q);
    c_page_set: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(page_q));
    c_protect: cover property (@(posedge ref_clk) disable iff (!nrst) swp_q);
endmodule

// ### verification/ssd_bus_master.sv
// Bus master model: start, stop and byte frames at 800 ns per bus clock.
// Assumes the bench resolves sda_wire from every party's pull-down.
`timescale 1ns/1ps
module ssd_bus_master
(
    input wire logic ref_clk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_pull_low
);
    // Both lines idle high until the first frame
    initial
    begin
        scl = 1'b1;
        sda_pull_low = 1'b0;
    end

    // Quarter bus period, counted on falling ref_clk edges
    task automatic qtr(input int n);
        repeat (2 * n) @(negedge ref_clk);
    endtask

    // Start: release sda with scl low, then drop it under a high scl
    task automatic start();
        qtr(1);
        sda_pull_low = 1'b0;
        qtr(2); // Extra quarter so a slave ack is gone before scl rises
        scl = 1'b1;
        qtr(1);
        sda_pull_low = 1'b1;
        qtr(1);
        scl = 1'b0;
    endtask

    // Stop: sda low with scl low, then raised under a high scl
    task automatic stop();
        qtr(1);
        sda_pull_low = 1'b1;
        qtr(1);
        scl = 1'b1;
        qtr(1);
        sda_pull_low = 1'b0;
        qtr(1);
    endtask

    // One bus clock; data moves only while scl is low
    task automatic clk_bit(input logic b, output logic r);
        qtr(1);
        sda_pull_low = ~b;
        qtr(1);
        scl = 1'b1;
        qtr(1);
        r = sda_wire;
        qtr(1);
        scl = 1'b0;
    endtask

    // Eight bits msb first, then the ninth clock; mack low means master ack
    task automatic xfer(input logic [7:0] b, input logic mack, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            clk_bit(b[i], r);
        clk_bit(mack, r);
        ack = ~r;
    endtask
endmodule

// ### verification/ssd_tb_top.sv
// Self-checking bench for the select-byte decoder top.
// Assumes ssd_bus_master drives the bus; sda has a pull-up modelled here.
`timescale 1ns/1ps
module ssd_tb_top;
    import ssd_pkg::*;
    // Strap address whose bit-reversed form differs
    localparam logic [2:0] ADDR = 3'h6;
    logic ref_clk, nrst, scl, sda_pull_low, sda_wire, sda_out, sda_oe_n, hv, write_busy;
    logic [2:0] strap;
    logic [3:0] prot_status;
    logic memory_page, set_block_protect, clear_all_protect, write_cycle_start;
    logic memory_standby, memory_selected, thermal_selected, read_dir;
    logic [1:0] protect_block;
    int err_total, cmp_count, n_wcs, n_stby, n_set, n_clr;

    // Open drain: any pull-down wins over the pull-up
    assign sda_wire = (sda_pull_low || (sda_oe_n === 1'b0 && sda_out === 1'b0)) ? 1'b0 : 1'b1;

    ssd_top u_ssd_top
    (
        .ref_clk(ref_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .strap_addr_bit0_hv_detect(strap[0]), .strap_addr_bit1(strap[1]), .strap_addr_bit2(strap[2]),
        .high_voltage_qualifier(hv), .write_busy(write_busy), .prot_status(prot_status),
        .memory_page(memory_page), .set_block_protect(set_block_protect),
        .protect_block(protect_block), .clear_all_protect(clear_all_protect),
        .write_cycle_start(write_cycle_start), .memory_standby(memory_standby),
        .memory_selected(memory_selected), .thermal_selected(thermal_selected), .read_dir(read_dir)
    );

    ssd_bus_master u_ssd_bus_master
    (
        .ref_clk(ref_clk), .sda_wire(sda_wire), .scl(scl), .sda_pull_low(sda_pull_low)
    );

    // 10 MHz reference clock
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Pulses are counted mid-cycle, away from the edge that launches them
    always @(negedge ref_clk)
    begin
        if (write_cycle_start === 1'b1) n_wcs++;
        if (memory_standby === 1'b1) n_stby++;
        if (set_block_protect === 1'b1) n_set++;
        if (clear_all_protect === 1'b1) n_clr++;
    end

    task automatic clr();
        n_wcs = 0;
        n_stby = 0;
        n_set = 0;
        n_clr = 0;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Reset pulse, then one idle bus period
    task automatic do_reset(input int n);
        nrst = 1'b0;
        repeat (n) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (8) @(negedge ref_clk);
    endtask

    // Whole frame: start, select byte, judge its ack, stop
    task automatic cmd(input logic [7:0] sel, input logic exp);
        logic a;
        u_ssd_bus_master.start();
        u_ssd_bus_master.xfer(sel, 1'b1, a);
        chk(a, exp, "select ack");
        u_ssd_bus_master.stop();
        repeat (8) @(negedge ref_clk);
    endtask

    task automatic t_mem_write();
        logic a;
        clr();
        u_ssd_bus_master.start();
        u_ssd_bus_master.xfer({TYPE_MEM, ADDR, 1'b0}, 1'b1, a);
        chk(a, 1'b1, "memory select ack");
        chk(memory_selected, 1'b1, "memory selected");
        chk(read_dir, 1'b0, "write direction");
        u_ssd_bus_master.xfer(8'h5A, 1'b1, a);
        u_ssd_bus_master.xfer(8'hC3, 1'b1, a);
        chk(a, 1'b1, "data ack");
        u_ssd_bus_master.stop();
        repeat (8) @(negedge ref_clk);
        chk(n_wcs == 1, 1'b1, "programming started");
        chk(memory_selected, 1'b0, "dropped by stop");
        // Stop with no data byte must not program
        clr();
        cmd({TYPE_MEM, ADDR, 1'b0}, 1'b1);
        chk(n_wcs == 0, 1'b1, "no programming");
    endtask

    task automatic t_mismatch();
        logic a;
        cmd({TYPE_MEM, 3'h3, 1'b0}, 1'b0);
        cmd({TYPE_TEMP, 3'h3, 1'b1}, 1'b0);
        // After a refused select the rest of the frame is ignored
        u_ssd_bus_master.start();
        u_ssd_bus_master.xfer({TYPE_MEM, 3'h3, 1'b0}, 1'b1, a);
        u_ssd_bus_master.xfer({TYPE_MEM, ADDR, 1'b0}, 1'b1, a);
        chk(a, 1'b0, "ignored until start");
        u_ssd_bus_master.stop();
    endtask

    task automatic t_busy_temp();
        logic a;
        write_busy = 1'b1;
        cmd({TYPE_MEM, ADDR, 1'b0}, 1'b0);
        clr();
        u_ssd_bus_master.start();
        u_ssd_bus_master.xfer({TYPE_TEMP, ADDR, 1'b1}, 1'b1, a);
        chk(a, 1'b1, "temp ack while busy");
        chk(thermal_selected, 1'b1, "temp selected");
        chk(read_dir, 1'b1, "read direction");
        chk(n_stby == 1, 1'b1, "memory standby");
        u_ssd_bus_master.stop();
        write_busy = 1'b0;
        repeat (8) @(negedge ref_clk);
        chk(thermal_selected, 1'b0, "temp dropped by stop");
    endtask

    task automatic t_mem_read();
        logic a;
        clr();
        u_ssd_bus_master.start();
        u_ssd_bus_master.xfer({TYPE_MEM, ADDR, 1'b1}, 1'b1, a);
        chk(a, 1'b1, "read select ack");
        u_ssd_bus_master.xfer(8'hFF, 1'b1, a);
        u_ssd_bus_master.stop();
        repeat (8) @(negedge ref_clk);
        chk(n_stby == 1, 1'b1, "standby after read");
    endtask

    task automatic t_protect();
        logic [3:0] codes [4] = '{CODE_SWP0, CODE_SWP1, CODE_SWP2, CODE_SWP3};
        logic [3:0] rsv [4] = '{4'h4, 4'h5, 4'h7, 4'hF};
        hv = 1'b1;
        strap[0] = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            clr();
            cmd({TYPE_PROT, codes[k]}, 1'b1);
            chk(n_set == 1, 1'b1, "set pulse");
            chk(protect_block, 8'(k), "block number");
        end
        clr();
        cmd({TYPE_PROT, CODE_CWP}, 1'b1);
        chk(n_clr == 1, 1'b1, "clear pulse");
        // Reserved codes and missing high voltage are refused
        clr();
        for (int k = 0; k < 4; k++)
            cmd({TYPE_PROT, rsv[k]}, 1'b0);
        hv = 1'b0;
        cmd({TYPE_PROT, CODE_SWP1}, 1'b0);
        cmd({TYPE_PROT, CODE_CWP}, 1'b0);
        chk(n_set + n_clr == 0, 1'b1, "no protect change");
        chk(memory_page, 1'b0, "page untouched");
        strap[0] = 1'b0;
    endtask

    task automatic t_status();
        logic a;
        logic [3:0] codes [4] = '{CODE_RPS0, CODE_RPS1, CODE_RPS2, CODE_RPS3};
        prot_status = 4'h5;
        for (int k = 0; k < 4; k++)
        begin
            hv = (k == 3);
            strap[0] = k[0];
            u_ssd_bus_master.start();
            u_ssd_bus_master.xfer({TYPE_PROT, codes[k]}, 1'b1, a);
            chk(a, 1'b1, "status select ack");
            u_ssd_bus_master.xfer(8'hFF, 1'b1, a);
            chk(a, !prot_status[k], "status data ack");
            u_ssd_bus_master.stop();
        end
        hv = 1'b0;
        strap[0] = 1'b0;
    endtask

    task automatic t_page();
        cmd({TYPE_PROT, CODE_SELECT_UPPER_PAGE}, 1'b1);
        chk(memory_page, 1'b1, "upper page");
        cmd({TYPE_PROT, CODE_RPA}, 1'b0);
        cmd({TYPE_PROT, CODE_SELECT_LOWER_PAGE}, 1'b1);
        chk(memory_page, 1'b0, "lower page");
        cmd({TYPE_PROT, CODE_RPA}, 1'b1);
        cmd({TYPE_PROT, CODE_SELECT_UPPER_PAGE}, 1'b1);
        do_reset(2);
        chk(memory_page, 1'b0, "page after reset");
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        nrst = 1'b0;
        hv = 1'b0;
        write_busy = 1'b0;
        prot_status = 4'h0;
        strap = ADDR;
        err_total = 0;
        cmp_count = 0;
        clr();
        do_reset(20);
        chk(memory_page, PAGE_RST, "page at start");
        chk(sda_oe_n, 1'b1, "sda released");
        chk(sda_out, 1'b1, "sda out idle");
        t_mem_write();
        t_mismatch();
        t_busy_temp();
        t_mem_read();
        t_protect();
        t_status();
        t_page();
        tally_and_finish();
    end

    // Watchdog well beyond the third of a millisecond the frames need
    initial
    begin
        #3000000;
        err_total++;
        tally_and_finish();
    end
endmodule
